// ### bench/fpga_port_model.sv
// model of the target logic device's serial configuration port
`timescale 1ns/100ps
module fpga_port_model (
    input wire logic sys_clk,
    input wire logic serial_data_out,
    input wire logic serial_data_oe,
    input wire logic oe_reset_oe,
    output logic cfg_clk,
    output logic oe_reset_wire,
    output logic data_wire
);
    // ==========================================================
    // wire state
    logic hold_low_reg = 1'b0; // target pulls the shared pin low
    logic last_bit_reg = 1'b0; // last value driven on the data line
    initial cfg_clk = 1'b0; // clock stands low between reads
    // open-drain with pull-up: low when either party pulls
    assign oe_reset_wire = ~(oe_reset_oe | hold_low_reg);
    // a released line never shows a stale value, so invert it
    assign data_wire = serial_data_oe ? serial_data_out : ~last_bit_reg;
    // remember what the memory last drove
    always @(posedge sys_clk) begin
        if (serial_data_oe) begin
            last_bit_reg <= serial_data_out;
        end
    end
    // ==========================================================
    // one configuration clock, each phase half_cyc cycles long
    task automatic cfg_pulse(input int half_cyc);
        @(posedge sys_clk);
        cfg_clk <= 1'b1;
        repeat (half_cyc) @(posedge sys_clk);
        cfg_clk <= 1'b0;
        repeat (half_cyc) @(posedge sys_clk);
    endtask
    // target holds or releases the shared enable/clear pin
    task automatic set_hold(input logic v);
        @(posedge sys_clk);
        hold_low_reg <= v;
    endtask
endmodule // fpga_port_model

// ### bench/serial_config_prom_readout_tb_top.sv
// self-checking bench for the configuration memory readout
`timescale 1ns/100ps
module serial_config_prom_readout_tb_top;
    import prom_pkg::*;
    // ==========================================================
    // bench setup, small image keeps the readout short
    localparam int WORDS = 4;
    localparam int BITS = WORDS * 8;
    localparam logic [7:0] IMG [WORDS] = '{8'ha5, 8'h3c, 8'hf0, 8'h96};
    logic sys_clk, nrst, clk_en, clk_sel, cs_n, tck, tms, tdi;
    logic isp, clamp, prog_we;
    logic [1:0] prog_addr;
    logic [7:0] prog_data;
    logic cfg_clk, oe_wire, data_wire;
    logic sdo, sdo_oe, oer_out, oer_oe, casc, rl_out, rl_oe;
    logic tdo_pin, tdo_en; // test data out and its enable
    logic next_cs_n; // chip select of a following memory
    pin_in_t pin_in; // pins as the memory sees them
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0; // cycles run, for the hang limit
    int pulse_len = 0; // length of the last reload pulse
    int pulse_cnt = 0; // reload pulses seen
    int run_len = 0;
    assign pin_in = {cfg_clk, clk_sel, cs_n, oe_wire, tck, tms, tdi};
    // chained system: cascade output drives the next chip select
    assign next_cs_n = casc;
    // ==========================================================
    // clock and hang limit
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc >= 20000) begin
            n_mismatch++;
            test_done();
        end
    end
    // measure every low pulse on the reload pin
    always @(posedge sys_clk) begin
        if (rl_oe === 1'b1) begin
            run_len++;
        end else if (run_len != 0) begin
            pulse_len = run_len;
            pulse_cnt++;
            run_len = 0;
        end
    end
    // ==========================================================
    // design and far side
    serial_config_prom_readout #(.WORDS(WORDS), .WORD_W(8)) u_dut (
        .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
        .pin_in(pin_in), .in_system_programming_active(isp),
        .clamp_active(clamp), .prog_we(prog_we), .prog_addr(prog_addr),
        .prog_data(prog_data), .serial_data_out(sdo),
        .serial_data_oe(sdo_oe), .oe_reset_out(oer_out),
        .oe_reset_oe(oer_oe), .cascade_select_out(casc),
        .fpga_reload_pulse_out(rl_out), .fpga_reload_pulse_oe(rl_oe),
        .tdo(tdo_pin), .tdo_oe(tdo_en));
    fpga_port_model u_fpga (
        .sys_clk(sys_clk), .serial_data_out(sdo), .serial_data_oe(sdo_oe),
        .oe_reset_oe(oer_oe), .cfg_clk(cfg_clk), .oe_reset_wire(oe_wire),
        .data_wire(data_wire));
    // ==========================================================
    // shared tasks
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // bit k of the stream: word k/8, most significant bit first
    function automatic logic exp_bit(input int k);
        return IMG[k / 8][7 - (k % 8)];
    endfunction
    // clock bits first..last, alternating fast and slow phases
    task automatic clock_bits(input int first, input int last);
        for (int k = first; k <= last; k++) begin
            u_fpga.cfg_pulse((k % 2 == 1) ? 2 : 4);
            #1;
            check("data_bit", data_wire, exp_bit(k));
            check("data_oe", sdo_oe, 1'b1);
            check("cascade_mid", casc, 1'b1);
        end
    endtask
    // one test clock with the given mode select and data
    task automatic tck_cycle(input logic m, input logic d);
        @(posedge sys_clk);
        tms <= m;
        tdi <= d;
        tick(3);
        tck <= 1'b1;
        tick(3);
        tck <= 1'b0;
    endtask
    // walk the tap to shift-IR, load an opcode lsb first, go idle
    task automatic load_ir(input logic [7:0] op);
        repeat (5) tck_cycle(1'b1, 1'b0);
        tck_cycle(1'b0, 1'b0);
        tck_cycle(1'b1, 1'b0);
        tck_cycle(1'b1, 1'b0);
        tck_cycle(1'b0, 1'b0);
        tck_cycle(1'b0, 1'b0);
        // first bit out of shift-IR is the capture value's lsb
        tick(3);
        #1;
        check("tdo_capture", {tdo_pin, tdo_en}, 2'b11);
        for (int i = 0; i < 8; i++) begin
            tck_cycle(i == 7, op[i]);
        end
        tck_cycle(1'b1, 1'b0);
        tck_cycle(1'b0, 1'b0);
    endtask
    // ==========================================================
    // scenarios
    // reset levels and the stretched internal reset on the pin
    task automatic reset_stretch();
        int n;
        n = 0;
        tick(2);
        #1;
        check("rst_data_oe", sdo_oe, 1'b0);
        check("rst_cascade", casc, 1'b1);
        check("rst_reload", rl_oe, 1'b0);
        check("rst_pin_pull", oer_oe, 1'b1);
        check("rst_pin_level", oer_out, 1'b0);
        @(posedge sys_clk);
        nrst <= 1'b1;
        while (oer_oe !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        check("rst_stretch", (n >= INT_RESET_CYC - 1) &&
              (n <= INT_RESET_CYC + 2), 1'b1);
    endtask
    // write the image while deselected
    task automatic load_image();
        for (int w = 0; w < WORDS; w++) begin
            @(posedge sys_clk);
            prog_we <= 1'b1;
            prog_addr <= w[1:0];
            prog_data <= IMG[w];
        end
        @(posedge sys_clk);
        prog_we <= 1'b0;
    endtask
    // full readout, past the end, then deselect and reselect
    task automatic readout_deselect();
        @(posedge sys_clk);
        cs_n <= 1'b0;
        tick(4);
        #1;
        check("first_bit", data_wire, exp_bit(0));
        clock_bits(1, BITS - 1);
        u_fpga.cfg_pulse(3);
        #1;
        check("end_float", sdo_oe, 1'b0);
        check("end_cascade", casc, 1'b0);
        check("next_select", next_cs_n, 1'b0);
        cs_n <= 1'b1;
        tick(5);
        #1;
        check("desel_cascade", casc, 1'b1);
        check("desel_float", sdo_oe, 1'b0);
        cs_n <= 1'b0;
        tick(4);
        #1;
        check("resel_bit", data_wire, exp_bit(0));
    endtask
    // enable pin pulled low after the end clears and floats
    task automatic enable_low_clear();
        clock_bits(1, BITS - 1);
        u_fpga.cfg_pulse(2);
        #1;
        check("end_cascade2", casc, 1'b0);
        u_fpga.set_hold(1'b1);
        tick(5);
        #1;
        check("oe_cascade", casc, 1'b1);
        check("oe_float", sdo_oe, 1'b0);
        u_fpga.cfg_pulse(3);
        u_fpga.set_hold(1'b0);
        tick(4);
        #1;
        check("oe_clear_bit", data_wire, exp_bit(0));
        check("oe_clear_casc", casc, 1'b1);
    endtask
    // edges ignored while unselected or frozen
    task automatic clock_gating();
        clk_sel <= 1'b0;
        u_fpga.cfg_pulse(3);
        u_fpga.cfg_pulse(3);
        #1;
        check("unsel_hold", data_wire, exp_bit(0));
        clk_sel <= 1'b1;
        clk_en <= 1'b0;
        u_fpga.cfg_pulse(3);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        tick(4);
        #1;
        check("frozen_hold", data_wire, exp_bit(0));
        clock_bits(1, 1);
    endtask
    // programming floats data unless clamped
    task automatic programming_float();
        @(posedge sys_clk);
        isp <= 1'b1;
        tick(3);
        #1;
        check("isp_float", sdo_oe, 1'b0);
        isp <= 1'b0;
        tick(3);
        #1;
        check("isp_back", sdo_oe, 1'b1);
        clamp <= 1'b1;
        @(posedge sys_clk);
        isp <= 1'b1;
        tick(3);
        #1;
        check("isp_clamped", sdo_oe, 1'b1);
        isp <= 1'b0;
        @(posedge sys_clk);
        clamp <= 1'b0;
    endtask
    // reload opcode pulses the reload pin, bypass does not
    task automatic reload_pulse();
        load_ir(IR_RELOAD);
        tick(60);
        #1;
        check("reload_count", pulse_cnt[7:0], 8'h01);
        check("reload_len", pulse_len[7:0], RELOAD_CYC[7:0]);
        check("reload_level", rl_out, 1'b0);
        check("tdo_idle_oe", tdo_en, 1'b0);
        load_ir(IR_BYPASS);
        tick(60);
        #1;
        check("bypass_none", pulse_cnt[7:0], 8'h01);
    endtask
    // ==========================================================
    // verdict and main sequence
    task automatic test_done();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        clk_sel = 1'b1;
        cs_n = 1'b1;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        isp = 1'b0;
        clamp = 1'b0;
        prog_we = 1'b0;
        prog_addr = 2'h0;
        prog_data = 8'h00;
        tick(1);
        reset_stretch();
        load_image();
        readout_deselect();
        enable_low_clear();
        clock_gating();
        programming_float();
        reload_pulse();
        test_done();
    end
endmodule // serial_config_prom_readout_tb_top

// ### hw/scan_tap.sv
// test access port controller with bypass and instruction register
`timescale 1ns/100ps
module scan_tap import prom_pkg::*; (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic tck_rise,
    input wire logic tck_fall,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    output logic reload_start
);

    // ==========================================================
    // state
    tap_state_t st_reg, st_next;
    logic [IR_LEN-1:0] ir_reg, ir_next;      // shift stage
    logic [IR_LEN-1:0] instr_reg, instr_next; // active instruction
    logic byp_reg, byp_next;
    logic tdo_reg, tdo_next;
    logic oe_reg, oe_next;

    // tap walk on each sampled tms level
    always_comb begin
        st_next = st_reg;
        if (tck_rise) begin
            case (st_reg)
                TAP_RESET: st_next = tms ? TAP_RESET : TAP_IDLE;
                TAP_IDLE: st_next = tms ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_DR: st_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: st_next = tms ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR: st_next = tms ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: st_next = tms ? TAP_UPD_DR : TAP_PA_DR;
                TAP_PA_DR: st_next = tms ? TAP_EX2_DR : TAP_PA_DR;
                TAP_EX2_DR: st_next = tms ? TAP_UPD_DR : TAP_SH_DR;
                TAP_UPD_DR: st_next = tms ? TAP_SEL_DR : TAP_IDLE;
                TAP_SEL_IR: st_next = tms ? TAP_RESET : TAP_CAP_IR;
                TAP_CAP_IR: st_next = tms ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR: st_next = tms ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: st_next = tms ? TAP_UPD_IR : TAP_PA_IR;
                TAP_PA_IR: st_next = tms ? TAP_EX2_IR : TAP_PA_IR;
                TAP_EX2_IR: st_next = tms ? TAP_UPD_IR : TAP_SH_IR;
                TAP_UPD_IR: st_next = tms ? TAP_SEL_DR : TAP_IDLE;
                default: st_next = TAP_RESET;
            endcase
        end
    end

    // shift paths, instruction update, tdo on falling test clock
    always_comb begin
        ir_next = ir_reg;
        instr_next = instr_reg;
        byp_next = byp_reg;
        tdo_next = tdo_reg;
        oe_next = oe_reg;
        if (tck_rise) begin
            case (st_reg)
                TAP_RESET: instr_next = IR_BYPASS;
                TAP_CAP_IR: ir_next = IR_CAPTURE;
                TAP_SH_IR: ir_next = {tdi, ir_reg[IR_LEN-1:1]};
                TAP_UPD_IR: instr_next = ir_reg;
                TAP_CAP_DR: byp_next = 1'b0;
                TAP_SH_DR: byp_next = tdi;
                default: ir_next = ir_reg;
            endcase
        end
        if (tck_fall) begin
            // tdo only driven while a shift state is active
            oe_next = (st_reg == TAP_SH_IR) || (st_reg == TAP_SH_DR);
            tdo_next = (st_reg == TAP_SH_IR) ? ir_reg[0] : byp_reg;
        end
    end

    // registers only
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_reg <= TAP_RESET;
            ir_reg <= IR_CAPTURE;
            instr_reg <= IR_BYPASS;
            byp_reg <= 1'b0;
            tdo_reg <= 1'b1;
            oe_reg <= 1'b0;
        end else if (clk_en) begin
            st_reg <= st_next;
            ir_reg <= ir_next;
            instr_reg <= instr_next;
            byp_reg <= byp_next;
            tdo_reg <= tdo_next;
            oe_reg <= oe_next;
        end
    end

    // reload runs when the tap enters idle holding that opcode; the
    // opcode being applied counts, so update-IR straight to idle fires
    assign reload_start = tck_rise && (st_reg != TAP_IDLE) &&
        (st_next == TAP_IDLE) && (instr_next == IR_RELOAD);
    assign tdo = tdo_reg;
    assign tdo_oe = oe_reg;

    // ==========================================================
    // checks
    chk_tap_leave_reset: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && tck_rise && !tms && st_reg == TAP_RESET
        |=> st_reg == TAP_IDLE)
        else $error("tap did not leave reset on low tms");

endmodule // scan_tap

// ### hw/serial_config_prom_readout.sv
// serial configuration memory readout: counter, data, cascade, reload
`timescale 1ns/100ps
// Behaviour
// - count rising config clock when selected, enabled
// - low output-enable holds counter clear, data floats
// - pull output-enable pin low during internal reset
// - chip select high: standby, clear, float data
// - stored bits appear on serial data output
// - data floats during programming unless clamped
// - reload instruction pulses reload output low
// - cascade low when selected, enabled, past terminal
// - cascade high once output-enable low or deselected
// - tap follows tms sampled on test clock
module serial_config_prom_readout import prom_pkg::*; #(
    parameter int WORDS = MEM_WORDS,
    parameter int WORD_W = MEM_WORD_W
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire pin_in_t pin_in,
    input wire logic in_system_programming_active,
    input wire logic clamp_active,
    input wire logic prog_we,
    input wire logic [$clog2(WORDS)-1:0] prog_addr,
    input wire logic [WORD_W-1:0] prog_data,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic oe_reset_out,
    output logic oe_reset_oe,
    output logic cascade_select_out,
    output logic fpga_reload_pulse_out,
    output logic fpga_reload_pulse_oe,
    output logic tdo,
    output logic tdo_oe
);

    // ==========================================================
    // sizes
    localparam int TOTAL = WORDS * WORD_W;   // stored bits
    localparam int CNT_W = $clog2(TOTAL);
    localparam int BIT_W = $clog2(WORD_W);
    localparam int WA_W = $clog2(WORDS);
    // last bit address before the counter runs past the end
    localparam logic [CNT_W-1:0] TERM = CNT_W'(TOTAL - 1);

    // ==========================================================
    // pin synchronisers
    logic [PIN_W-1:0] sync1_reg;  // first stage, read only by stage two
    logic [PIN_W-1:0] sync2_reg;  // stable copy used by the logic
    logic [PIN_W-1:0] sync3_reg;  // delayed copy for edge detection
    pin_in_t pins_s;              // synchronised pins as a struct
    logic cfg_rise;
    logic tck_rise;
    logic tck_fall;

    // each pin passes two flops before any logic looks at it
    generate
        for (genvar i = 0; i < PIN_W; i++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (!nrst) begin
                    sync1_reg[i] <= 1'b0;
                    sync2_reg[i] <= 1'b0;
                    sync3_reg[i] <= 1'b0;
                end else if (clk_en) begin
                    sync1_reg[i] <= pin_in[i];
                    sync2_reg[i] <= sync1_reg[i];
                    sync3_reg[i] <= sync2_reg[i];
                end
            end
        end
    endgenerate

    assign pins_s = pin_in_t'(sync2_reg);
    // edges come from stage two against stage three only
    assign cfg_rise = sync2_reg[6] && !sync3_reg[6];
    assign tck_rise = sync2_reg[2] && !sync3_reg[2];
    assign tck_fall = !sync2_reg[2] && sync3_reg[2];

    // ==========================================================
    // internal reset stretch
    logic [TIMER_W-1:0] rst_cnt_reg, rst_cnt_next;
    logic rst_busy;

    // counts down after release; pin held low meanwhile
    always_comb begin
        rst_cnt_next = rst_cnt_reg;
        if (rst_busy) begin
            rst_cnt_next = rst_cnt_reg - TIMER_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rst_cnt_reg <= TIMER_W'(INT_RESET_CYC);
        end else if (clk_en) begin
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    assign rst_busy = (rst_cnt_reg != '0);
    // open drain: value is always low, only the enable moves
    assign oe_reset_out = 1'b0;
    assign oe_reset_oe = rst_busy;

    // ==========================================================
    // stored bits
    logic [WORD_W-1:0] mem [WORDS];  // configuration image
    logic cur_bit;                   // bit at the current address

    // image loading port; no reset, contents are data
    always_ff @(posedge sys_clk) begin
        if (clk_en && prog_we) begin
            mem[prog_addr] <= prog_data;
        end
    end

    // ==========================================================
    // address counter
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic past_reg, past_next;    // counter ran past terminal count
    logic ce_act;                 // chip selected
    logic oe_hi;                  // output-enable/clear pin high
    logic clear;

    assign ce_act = !pins_s.chip_select_n;
    assign oe_hi = pins_s.oe_reset_in;
    // any of these holds the counter at zero
    assign clear = !ce_act || !oe_hi || rst_busy;

    // word index high bits, bit within word low bits, msb first
    assign cur_bit = mem[cnt_reg[CNT_W-1:BIT_W]]
        [BIT_W'(WORD_W - 1) - cnt_reg[BIT_W-1:0]];

    always_comb begin
        cnt_next = cnt_reg;
        past_next = past_reg;
        if (clear) begin
            // deselect or low enable resets the walk
            cnt_next = '0;
            past_next = 1'b0;
        end else if (cfg_rise && pins_s.cfg_clk_sel && !past_reg) begin
            if (cnt_reg == TERM) begin
                // one edge beyond the end marks the hand-over
                past_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cnt_reg <= '0;
            past_reg <= 1'b0;
        end else if (clk_en) begin
            cnt_reg <= cnt_next;
            past_reg <= past_next;
        end
    end

    // ==========================================================
    // serial data and cascade outputs
    logic data_reg, data_next;
    logic doe_reg, doe_next;
    logic cas_reg, cas_next;

    always_comb begin
        // normal drive: selected, enabled, not beyond the end
        doe_next = ce_act && oe_hi && !past_reg && !rst_busy;
        data_next = cur_bit;
        if (past_reg) begin
            // let the next memory in the chain own the data line
            doe_next = 1'b0;
        end
        if (in_system_programming_active) begin
            // clamp keeps the last driven level, else float
            doe_next = clamp_active && doe_reg;
            data_next = data_reg;
        end
        // cascade goes low only once this memory is exhausted
        cas_next = !(ce_act && oe_hi && past_reg);
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            data_reg <= 1'b0;
            doe_reg <= 1'b0;
            cas_reg <= 1'b1;
        end else if (clk_en) begin
            data_reg <= data_next;
            doe_reg <= doe_next;
            cas_reg <= cas_next;
        end
    end

    assign serial_data_out = data_reg;
    assign serial_data_oe = doe_reg;
    // feeds the chip select of the following memory
    assign cascade_select_out = cas_reg;

    // ==========================================================
    // reload pulse towards the target
    logic reload_start;
    logic [TIMER_W-1:0] rl_cnt_reg, rl_cnt_next;

    scan_tap u_tap (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .tck_rise(tck_rise),
        .tck_fall(tck_fall),
        .tms(pins_s.tms),
        .tdi(pins_s.tdi),
        .tdo(tdo),
        .tdo_oe(tdo_oe),
        .reload_start(reload_start)
    );

    // a new start restarts the full pulse width
    always_comb begin
        rl_cnt_next = rl_cnt_reg;
        if (reload_start) begin
            rl_cnt_next = TIMER_W'(RELOAD_CYC);
        end else if (rl_cnt_reg != '0) begin
            rl_cnt_next = rl_cnt_reg - TIMER_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rl_cnt_reg <= '0;
        end else if (clk_en) begin
            rl_cnt_reg <= rl_cnt_next;
        end
    end

    // open drain: pulled low while the timer runs
    assign fpga_reload_pulse_out = 1'b0;
    assign fpga_reload_pulse_oe = (rl_cnt_reg != '0);

    // ==========================================================
    // checks
    chk_count_advance: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && !clear && cfg_rise && pins_s.cfg_clk_sel &&
        !past_reg && cnt_reg != TERM
        |=> cnt_reg == $past(cnt_reg) + CNT_W'(1))
        else $error("counter did not advance on config clock");

    chk_oe_clear: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && !oe_hi && !in_system_programming_active
        |=> cnt_reg == '0 && !serial_data_oe)
        else $error("low output enable did not clear and float");

    chk_reset_pull: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        $rose(nrst) |-> oe_reset_oe [*8])
        else $error("enable pin not held low after reset");

    chk_standby: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && pins_s.chip_select_n && !in_system_programming_active
        |=> cnt_reg == '0 && !past_reg && !serial_data_oe)
        else $error("deselect did not clear and float");

    chk_data_bit: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && !in_system_programming_active && doe_next
        |=> serial_data_out == $past(cur_bit))
        else $error("data output is not the addressed bit");

    chk_isp_float: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && in_system_programming_active && !clamp_active
        |=> !serial_data_oe)
        else $error("data driven during programming");

    chk_reload_pulse: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && reload_start
        |=> fpga_reload_pulse_oe && rl_cnt_reg == TIMER_W'(RELOAD_CYC))
        else $error("reload pulse did not start");

    chk_cascade_low: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && ce_act && oe_hi && past_reg |=> !cascade_select_out)
        else $error("cascade not low after terminal count");

    chk_cascade_high: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && (!oe_hi || !ce_act) |=> cascade_select_out)
        else $error("cascade not released");

    chk_float_after_tc: assert property (@(posedge sys_clk)
        disable iff (!nrst)
        clk_en && past_reg |=> !serial_data_oe)
        else $error("data still driven past terminal count");

endmodule // serial_config_prom_readout

// ### inc/prom_pkg.sv
// shared constants and types for the serial configuration memory readout
package prom_pkg;

    // ==========================================================
    // clock and time constants
    localparam int CLK_PERIOD_NS = 25;
    // internal reset stretch, pin held low meanwhile
    localparam int INT_RESET_NS = 2000;
    localparam int INT_RESET_CYC =
        (INT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // width of the low pulse on the reload output
    localparam int RELOAD_PULSE_NS = 1000;
    localparam int RELOAD_CYC =
        (RELOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 7;

    // ==========================================================
    // storage defaults
    localparam int MEM_WORDS = 256;
    localparam int MEM_WORD_W = 8;

    // ==========================================================
    // test access port constants
    localparam int IR_LEN = 8;
    localparam logic [7:0] IR_CAPTURE = 8'h01;
    localparam logic [7:0] IR_BYPASS = 8'hff;
    // reload opcode: arbitrary value
    localparam logic [7:0] IR_RELOAD = 8'h5a;

    // tap states, gray coded along the usual walk
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3,
        TAP_CAP_DR = 4'h2, TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7,
        TAP_PA_DR = 4'h5, TAP_EX2_DR = 4'h4, TAP_UPD_DR = 4'hc,
        TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SH_IR = 4'he,
        TAP_EX1_IR = 4'ha, TAP_PA_IR = 4'hb, TAP_EX2_IR = 4'h9,
        TAP_UPD_IR = 4'h8
    } tap_state_t;

    // ==========================================================
    // pins arriving from outside the clock domain
    localparam int PIN_W = 7;
    typedef struct packed {
        logic cfg_clk;        // configuration clock pin
        logic cfg_clk_sel;    // configuration clock selected
        logic chip_select_n;  // chip select, active low
        logic oe_reset_in;    // level seen on output-enable/clear pin
        logic tck;            // test clock
        logic tms;            // test mode select
        logic tdi;            // test data in
    } pin_in_t;

endpackage
